// [rtl/supply_reset_supervisor_defs.svh]
`ifndef SUPPLY_RESET_SUPERVISOR_DEFS_SVH
`define SUPPLY_RESET_SUPERVISOR_DEFS_SVH

`define SRS_CLK_HZ          20000000
`define SRS_TIMEOUT_MS      200
`define SRS_TIMEOUT_CYCLES  ((`SRS_CLK_HZ / 1000) * `SRS_TIMEOUT_MS)
`define SRS_TIMEOUT_W       22
`define SRS_DEBOUNCE_NS     1000
`define SRS_DEBOUNCE_CYCLES (((`SRS_DEBOUNCE_NS * (`SRS_CLK_HZ / 1000000)) + 999) / 1000)
`define SRS_DEBOUNCE_W      5
`define SRS_PAGE_BYTES      16
`define SRS_PAGE_AW         4
`define SRS_ADDR_W          8
`define SRS_DATA_W          8
`define SRS_MR_IDLE         1'b1
`define SRS_WP_IDLE         1'b0

`endif

// [rtl/supervisor_pkg.sv]
`include "supply_reset_supervisor_defs.svh"

package supervisor_pkg;

    typedef struct packed {
        logic level;
        logic driven;
    } pin_in_type;

    typedef struct packed {
        logic level;
        logic oe;
    } od_pin_out_type;

    typedef struct packed {
        logic                     strobe;
        logic [`SRS_ADDR_W-1:0]   addr;
        logic [`SRS_DATA_W-1:0]   data;
    } byte_write_type;

    typedef enum logic [0:0] {
        ST_LOAD,
        ST_PROG
    } page_state_type;

endpackage

// [rtl/input_debouncer.sv]
`timescale 1ns/1ps
`default_nettype none
`include "supply_reset_supervisor_defs.svh"

module input_debouncer (
    input  wire logic ref_clk_in,
    input  wire logic rst_b_in,
    input  wire logic raw_in,
    output logic      clean_out
);
    typedef struct packed {
        logic                       stable;
        logic [`SRS_DEBOUNCE_W-1:0] cnt;
    } deb_state_type;

    localparam logic [`SRS_DEBOUNCE_W-1:0] LAST =
        `SRS_DEBOUNCE_W'(`SRS_DEBOUNCE_CYCLES - 1);

    deb_state_type q;
    deb_state_type next_q;

    // a level must hold for the whole window before it is believed
    always_comb begin
        next_q = q;
        if (raw_in != q.stable) begin
            if (q.cnt == LAST) begin
                next_q.stable = raw_in;
                next_q.cnt    = '0;
            end else begin
                next_q.cnt = q.cnt + 1'b1;
            end
        end else begin
            next_q.cnt = '0;
        end
        if (!rst_b_in) begin
            next_q.stable = `SRS_MR_IDLE;
            next_q.cnt    = '0;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        q <= next_q;
    end

    assign clean_out = q.stable;
endmodule // input_debouncer

`default_nettype wire

// [rtl/page_buffer.sv]
`timescale 1ns/1ps
`default_nettype none
`include "supply_reset_supervisor_defs.svh"

module page_buffer (
    input  wire logic                     ref_clk_in,
    input  wire logic                     rst_b_in,
    input  wire logic                     wr_en_in,
    input  wire logic [`SRS_PAGE_AW-1:0]  wr_addr_in,
    input  wire logic [`SRS_DATA_W-1:0]   wr_data_in,
    input  wire logic [`SRS_PAGE_AW-1:0]  rd_addr_in,
    output logic      [`SRS_DATA_W-1:0]   rd_data_out
);
    typedef struct packed {
        logic [`SRS_PAGE_BYTES-1:0][`SRS_DATA_W-1:0] mem;
        logic [`SRS_DATA_W-1:0]                      rd_data;
    } buf_state_type;

    buf_state_type q;
    buf_state_type next_q;

    always_comb begin
        next_q         = q;
        next_q.rd_data = q.mem[rd_addr_in];
        if (wr_en_in) begin
            next_q.mem[wr_addr_in] = wr_data_in;
        end
        if (!rst_b_in) begin
            next_q = '0;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        q <= next_q;
    end

    assign rd_data_out = q.rd_data;
endmodule // page_buffer

`default_nettype wire

// [rtl/supply_reset_supervisor.sv]
`timescale 1ns/1ps
`default_nettype none
`include "supply_reset_supervisor_defs.svh"

module supply_reset_supervisor #(
    parameter int unsigned TIMEOUT_CYCLES = `SRS_TIMEOUT_CYCLES
) (
    input  wire logic                         ref_clk_in,
    input  wire logic                         rst_b_in,
    input  wire logic                         supply_low_in,
    input  wire supervisor_pkg::pin_in_type   manual_reset_in,
    input  wire supervisor_pkg::pin_in_type   write_protect_in,
    input  wire logic                         reset_b_pin_in,
    input  wire supervisor_pkg::byte_write_type byte_write_in,
    input  wire logic                         page_commit_in,
    output supervisor_pkg::od_pin_out_type    reset_hi_out,
    output supervisor_pkg::od_pin_out_type    reset_b_out,
    output supervisor_pkg::byte_write_type    prog_out,
    output logic                              write_refused_out,
    output logic                              write_inhibit_out,
    output logic                              page_busy_out
);
    import supervisor_pkg::*;

    typedef struct packed {
        logic                        in_reset;
        logic [`SRS_TIMEOUT_W-1:0]   count;
        od_pin_out_type              rst_hi;
        od_pin_out_type              rst_lo;
        logic                        powered_seen;
        page_state_type              pstate;
        logic [`SRS_PAGE_BYTES-1:0]  mask;
        logic [`SRS_ADDR_W-`SRS_PAGE_AW-1:0] page;
        logic [`SRS_PAGE_AW-1:0]     idx;
        logic                        rd_pending;
        logic [`SRS_PAGE_AW-1:0]     rd_idx;
        byte_write_type              prog;
        logic                        refused;
        logic                        inhibit;
        logic                        busy;
    } sup_state_type;

    localparam logic [`SRS_TIMEOUT_W-1:0] TIMEOUT_LAST =
        `SRS_TIMEOUT_W'(TIMEOUT_CYCLES - 1);
    localparam logic [`SRS_PAGE_AW-1:0] LAST_IDX = `SRS_PAGE_AW'(`SRS_PAGE_BYTES - 1);

    // resolves a pin with a weak internal pull: undriven reads as the pull level
    function automatic logic pin_level(input pin_in_type pin, input logic pull);
        pin_level = pin.driven ? pin.level : pull;
    endfunction

    // byte slot inside the 16-byte page
    function automatic logic [`SRS_PAGE_AW-1:0] slot_of(input logic [`SRS_ADDR_W-1:0] addr);
        slot_of = addr[`SRS_PAGE_AW-1:0];
    endfunction

    // page number: the upper address bits shared by every byte of a page
    function automatic logic [`SRS_ADDR_W-`SRS_PAGE_AW-1:0] page_of(
        input logic [`SRS_ADDR_W-1:0] addr
    );
        page_of = addr[`SRS_ADDR_W-1:`SRS_PAGE_AW];
    endfunction

    sup_state_type                q;
    sup_state_type                next_q;
    logic                         mr_raw;
    logic                         mr_clean;
    logic                         wp_level;
    logic                         ext_pull;
    logic                         src_active;
    logic                         write_ok;
    logic                         mem_we;
    logic [`SRS_PAGE_AW-1:0]      mem_wa;
    logic [`SRS_DATA_W-1:0]       mem_wd;
    logic [`SRS_PAGE_AW-1:0]      mem_ra;
    logic [`SRS_DATA_W-1:0]       mem_rd;

    assign mr_raw   = pin_level(manual_reset_in, `SRS_MR_IDLE);
    assign wp_level = pin_level(write_protect_in, `SRS_WP_IDLE);

    input_debouncer u_mr_debounce (
        .ref_clk_in (ref_clk_in),
        .rst_b_in   (rst_b_in),
        .raw_in     (mr_raw),
        .clean_out  (mr_clean)
    );

    page_buffer u_page_buffer (
        .ref_clk_in  (ref_clk_in),
        .rst_b_in    (rst_b_in),
        .wr_en_in    (mem_we),
        .wr_addr_in  (mem_wa),
        .wr_data_in  (mem_wd),
        .rd_addr_in  (mem_ra),
        .rd_data_out (mem_rd)
    );

    // while we pull the pin ourselves its low level says nothing about the outside
    assign ext_pull   = !q.rst_lo.oe && !reset_b_pin_in;
    assign src_active = supply_low_in || !mr_clean || ext_pull;
    assign write_ok   = q.powered_seen && !supply_low_in && !wp_level;

    always_comb begin
        next_q             = q;
        next_q.prog        = '0;
        next_q.refused     = 1'b0;
        mem_we             = 1'b0;
        mem_wa             = slot_of(byte_write_in.addr);
        mem_wd             = byte_write_in.data;
        mem_ra             = q.idx;

        // reset timing
        if (src_active) begin
            next_q.in_reset = 1'b1;
            next_q.count    = '0;
        end else if (q.in_reset) begin
            if (q.count == TIMEOUT_LAST) begin
                next_q.in_reset = 1'b0;
            end else begin
                next_q.count = q.count + 1'b1;
            end
        end
        // open drain: only the asserted level is ever driven
        next_q.rst_hi.level = 1'b1;
        next_q.rst_hi.oe    = next_q.in_reset;
        next_q.rst_lo.level = 1'b0;
        next_q.rst_lo.oe    = next_q.in_reset;

        if (!supply_low_in) begin
            next_q.powered_seen = 1'b1;
        end

        case (q.pstate)
            ST_LOAD: begin
                if (byte_write_in.strobe) begin
                    if (write_ok) begin
                        mem_we = 1'b1;
                        next_q.mask[slot_of(byte_write_in.addr)] = 1'b1;
                        next_q.page = page_of(byte_write_in.addr);
                    end else begin
                        next_q.refused = 1'b1;
                    end
                end
                if (page_commit_in) begin
                    if (!write_ok) begin
                        // a refused page is dropped so it cannot program later
                        next_q.refused = 1'b1;
                        next_q.mask    = '0;
                    end else if (next_q.mask != '0) begin
                        next_q.pstate     = ST_PROG;
                        next_q.idx        = '0;
                        next_q.rd_pending = 1'b0;
                    end
                end
            end
            ST_PROG: begin
                if (byte_write_in.strobe) begin
                    next_q.refused = 1'b1;
                end
                if (!write_ok) begin
                    // protection rising mid-page stops the rest of the page
                    next_q.pstate     = ST_LOAD;
                    next_q.mask       = '0;
                    next_q.rd_pending = 1'b0;
                    next_q.refused    = 1'b1;
                end else begin
                    next_q.rd_pending = 1'b1;
                    next_q.rd_idx     = q.idx;
                    next_q.idx        = q.idx + 1'b1;
                    if (q.rd_pending && q.mask[q.rd_idx]) begin
                        next_q.prog.strobe = 1'b1;
                        next_q.prog.addr   = {q.page, q.rd_idx};
                        next_q.prog.data   = mem_rd;
                    end
                    if (q.rd_pending && q.rd_idx == LAST_IDX) begin
                        next_q.pstate     = ST_LOAD;
                        next_q.mask       = '0;
                        next_q.rd_pending = 1'b0;
                    end
                end
            end
            default: begin
                next_q.pstate = ST_LOAD;
            end
        endcase

        next_q.inhibit = !write_ok;
        // busy kept as its own flop so the output needs no decode after the register
        next_q.busy    = (next_q.pstate == ST_PROG);

        if (!rst_b_in) begin
            next_q           = '0;
            next_q.pstate    = ST_LOAD;
            next_q.in_reset  = 1'b1;
            next_q.rst_hi    = '{level: 1'b1, oe: 1'b1};
            next_q.rst_lo    = '{level: 1'b0, oe: 1'b1};
            next_q.inhibit   = 1'b1;
            mem_we           = 1'b0;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        q <= next_q;
    end

    assign reset_hi_out      = q.rst_hi;
    assign reset_b_out       = q.rst_lo;
    assign prog_out          = q.prog;
    assign write_refused_out = q.refused;
    assign write_inhibit_out = q.inhibit;
    assign page_busy_out     = q.busy;
endmodule // supply_reset_supervisor

`default_nettype wire

// [tb/supervisor_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
module supervisor_monitor #(
    parameter int unsigned TIMEOUT_CYCLES = 50
) (
    input wire logic                           ref_clk_in,
    input wire logic                           rst_b_in,
    input wire logic                           supply_low_in,
    input wire supervisor_pkg::pin_in_type     manual_reset_in,
    input wire supervisor_pkg::pin_in_type     write_protect_in,
    input wire logic                           reset_b_pin_in,
    input wire supervisor_pkg::byte_write_type byte_write_in,
    input wire logic                           page_commit_in,
    input wire supervisor_pkg::od_pin_out_type reset_hi_out,
    input wire supervisor_pkg::od_pin_out_type reset_b_out,
    input wire supervisor_pkg::byte_write_type prog_out,
    input wire logic                           write_refused_out,
    input wire logic                           write_inhibit_out,
    input wire logic                           page_busy_out
);
    import supervisor_pkg::*;
    logic        mr_low;
    logic        ext_low;
    int unsigned idle_cnt;
    int unsigned mr_cnt;
    assign mr_low  = manual_reset_in.driven && !manual_reset_in.level;
    assign ext_low = !reset_b_pin_in && !reset_b_out.oe;
    // a button low for 21 samples is surely past the debouncer, so the idle
    // count here never starts later than the design's own
    always_ff @(posedge ref_clk_in) begin
        if (!rst_b_in) begin
            mr_cnt   <= 0;
            idle_cnt <= 0;
        end else begin
            mr_cnt   <= mr_low ? mr_cnt + 1 : 0;
            idle_cnt <= (supply_low_in || ext_low || mr_cnt >= 21) ? 0 : idle_cnt + 1;
        end
    end
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!rst_b_in);
    a_supply_asserts: assert property (supply_low_in |=> reset_hi_out.oe && reset_b_out.oe)
        else $error("reset outputs not asserted after supply low");
    a_level_pairing: assert property (reset_hi_out.oe == reset_b_out.oe
        && reset_hi_out.level && !reset_b_out.level)
        else $error("reset outputs disagree or drive an idle level");
    a_timeout_hold: assert property ($fell(reset_b_out.oe) |-> idle_cnt >= TIMEOUT_CYCLES - 1)
        else $error("reset released before the timeout");
    a_release_due: assert property (idle_cnt == TIMEOUT_CYCLES + 48 |-> !reset_b_out.oe)
        else $error("reset still held long after sources went idle");
    a_manual_holds: assert property (mr_cnt >= 24 |-> reset_b_out.oe)
        else $error("manual reset held low without reset");
    a_rise_cause: assert property ($rose(reset_b_out.oe) |-> $past(supply_low_in)
        || $past(ext_low) || $past(mr_cnt) >= 19 || $past(mr_cnt, 2) >= 19)
        else $error("reset began without a lasting cause");
    a_external_pull: assert property (ext_low |=> reset_b_out.oe)
        else $error("external pull on reset pin ignored");
    a_protect_refuses: assert property (write_protect_in.driven && write_protect_in.level
        && byte_write_in.strobe |=> write_refused_out)
        else $error("protected byte write not refused");
    a_supply_inhibits: assert property (supply_low_in |=> write_inhibit_out)
        else $error("writes not inhibited with supply low");
    a_prog_in_page: assert property (prog_out.strobe |-> $past(page_busy_out))
        else $error("byte programmed outside a page cycle");
    c_release: cover property ($fell(reset_b_out.oe));
    c_manual: cover property (mr_cnt == 24);
    c_program: cover property (prog_out.strobe ##1 prog_out.strobe);
endmodule // supervisor_monitor
bind supply_reset_supervisor supervisor_monitor #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES))
    supervisor_monitor_i (.ref_clk_in, .rst_b_in, .supply_low_in, .manual_reset_in,
    .write_protect_in, .reset_b_pin_in, .byte_write_in, .page_commit_in, .reset_hi_out,
    .reset_b_out, .prog_out, .write_refused_out, .write_inhibit_out, .page_busy_out);
`default_nettype wire

// [tb/host_mcu_model.sv]
`timescale 1ns/1ps
`default_nettype none
module host_mcu_model (
    input  wire supervisor_pkg::od_pin_out_type reset_hi_in,
    input  wire supervisor_pkg::od_pin_out_type reset_b_in,
    input  wire logic                           pull_low_in,
    output logic                                reset_b_wire_out,
    output logic                                reset_hi_wire_out
);
    import supervisor_pkg::*;
    // pull-up wire: any party pulling low wins, otherwise it floats high
    assign reset_b_wire_out  = !((reset_b_in.oe && !reset_b_in.level) || pull_low_in);
    // pull-down resistor gives the idle level of the active-high wire
    assign reset_hi_wire_out = reset_hi_in.oe && reset_hi_in.level;
endmodule // host_mcu_model
`default_nettype wire

// [tb/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import supervisor_pkg::*;
    localparam int T = 50;
    logic           ref_clk = 1'b0;
    logic           rst_b = 1'b0;
    logic           supply_low = 1'b1;
    pin_in_type     manual_reset = 2'b11;
    pin_in_type     write_protect = 2'b00;
    byte_write_type byte_write = '0;
    logic           commit = 1'b0;
    logic           pull_low = 1'b0;
    logic           pin_level, hi_level, refused, inhibit, busy, rf, bs;
    od_pin_out_type reset_hi, reset_b;
    byte_write_type prog;
    logic [7:0]     exp_data [16];
    logic [3:0]     page = 4'h0;
    int             errors = 0;
    int             n_checks = 0;
    int             n, np;
    always #25 ref_clk = ~ref_clk;
    supply_reset_supervisor #(.TIMEOUT_CYCLES(T)) supply_reset_supervisor_i (
        .ref_clk_in(ref_clk), .rst_b_in(rst_b), .supply_low_in(supply_low),
        .manual_reset_in(manual_reset), .write_protect_in(write_protect),
        .reset_b_pin_in(pin_level), .byte_write_in(byte_write), .page_commit_in(commit),
        .reset_hi_out(reset_hi), .reset_b_out(reset_b), .prog_out(prog),
        .write_refused_out(refused), .write_inhibit_out(inhibit), .page_busy_out(busy));
    host_mcu_model host_mcu_model_i (.reset_hi_in(reset_hi), .reset_b_in(reset_b),
        .pull_low_in(pull_low), .reset_b_wire_out(pin_level), .reset_hi_wire_out(hi_level));
    task automatic cyc(input int k);
        repeat (k) @(posedge ref_clk);
    endtask
    task automatic chk(input logic [16:0] seen, input logic [16:0] expv);
        n_checks++;
        if (seen !== expv) begin
            errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, expv);
        end
    endtask
    task automatic end_sim;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic wait_rel;
        n = 0;
        @(negedge ref_clk);
        while (reset_b.oe !== 1'b0) begin
            n++;
            if (n > 4 * T) begin
                errors++;
                $display("mismatch at %0t: reset never released", $time);
                end_sim();
            end
            @(negedge ref_clk);
        end
    endtask
    // expected programming word for the i-th byte of the current page
    function automatic logic [16:0] exp_prog(input int i);
        return {1'b1, page, i[3:0], exp_data[i[3:0]]};
    endfunction
    // gathers refusals and busy, checks each programmed byte against the page image
    task automatic watch(input int k);
        for (int i = 0; i < k; i++) begin
            @(negedge ref_clk);
            rf |= refused;
            bs |= busy;
            if (prog.strobe === 1'b1) begin
                chk(prog, exp_prog(np));
                np++;
            end
        end
    endtask
    task automatic wr(input logic [3:0] idx, input logic [7:0] d);
        @(posedge ref_clk);
        byte_write <= '{1'b1, {page, idx}, d};
        @(posedge ref_clk);
        byte_write.strobe <= 1'b0;
    endtask
    task automatic commit_page;
        @(posedge ref_clk);
        commit <= 1'b1;
        @(posedge ref_clk);
        commit <= 1'b0;
        np = 0;
        rf = 1'b0;
        bs = 1'b0;
        watch(40);
    endtask
    initial begin
        void'($urandom(16));
        cyc(8);
        rst_b <= 1'b1;
        cyc(3 + $urandom % 5);
        @(negedge ref_clk);
        chk(17'({reset_hi.oe, reset_b.oe, hi_level, pin_level, inhibit}), 17'h1d);
        exp_data[0] = 8'h00;
        wr(4'h0, 8'h00);
        commit_page();
        chk(17'({rf, np[3:0]}), 17'h10);
        cyc(1);
        supply_low <= 1'b0;
        cyc(T / 2);
        supply_low <= 1'b1;
        cyc(1 + $urandom % 3);
        supply_low <= 1'b0;
        wait_rel();
        chk(17'(n >= T - 1 && n <= T + 3), 17'h1);
        $display("test supply done");
        manual_reset <= 2'b00;
        cyc(30);
        @(negedge ref_clk);
        chk(17'(reset_b.oe), 17'h0);
        for (int i = 0; i < 6; i++) begin
            cyc(1);
            manual_reset <= 2'b01;
            cyc(1 + $urandom % 15);
            manual_reset <= 2'b11;
            cyc(2 + $urandom % 4);
            @(negedge ref_clk);
            chk(17'(reset_b.oe), 17'h0);
        end
        cyc(1);
        manual_reset <= 2'b01;
        cyc(25 + $urandom % 30);
        @(negedge ref_clk);
        chk(17'({reset_hi.oe, reset_b.oe}), 17'h3);
        cyc(1);
        manual_reset <= 2'b11;
        wait_rel();
        chk(17'(n >= T && n <= T + 30), 17'h1);
        $display("test manual done");
        cyc(1);
        pull_low <= 1'b1;
        cyc(3);
        @(negedge ref_clk);
        chk(17'({reset_hi.oe, reset_b.oe}), 17'h3);
        cyc(1);
        pull_low <= 1'b0;
        wait_rel();
        chk(17'(n > 0 && n <= T + 3), 17'h1);
        $display("test pin pull done");
        write_protect <= 2'b10;
        page = 4'($urandom);
        wr(4'h0, 8'h5a);
        for (int i = 0; i < 16; i++) begin
            exp_data[i] = 8'($urandom);
            wr(4'(i), exp_data[i]);
        end
        commit_page();
        chk(17'({bs, rf, np[4:0]}), 17'h50);
        cyc(1);
        write_protect <= 2'b11;
        wr(4'h3, 8'($urandom));
        commit_page();
        chk(17'({bs, rf, np[4:0]}), 17'h20);
        $display("test page write done");
        end_sim();
    end
endmodule // tb_top
`default_nettype wire
